// file: tchi_defs.svh
// Offsets, field positions, reset values and encodings of the tape
// control host interface.
// Assumes inclusion by bare name from the design files only.
`ifndef TCHI_DEFS_SVH
`define TCHI_DEFS_SVH

// Register byte offsets on the Avalon slave
`define TCHI_OFS_STATUS 4'h0
`define TCHI_OFS_DATA 4'h4
`define TCHI_OFS_CTRL 4'h8

// Host word bit positions, bit 0 is the most significant line
`define TCHI_GO_BIT 12
`define TCHI_DIR_BIT 13
`define TCHI_MODE_LO 15
`define TCHI_MODE_HI 17
`define TCHI_UNIT_LO 2
`define TCHI_UNIT_HI 5

// Mode encodings
`define TCHI_MODE_MOVE 3'h0
`define TCHI_MODE_SEARCH 3'h1
`define TCHI_MODE_READ 3'h2
`define TCHI_MODE_WRITE 3'h3

// Status register bit positions
`define TCHI_ST_DATA 0
`define TCHI_ST_BLOCK 1
`define TCHI_ST_ERROR 2
`define TCHI_ST_END 3
`define TCHI_ST_MISS 4
`define TCHI_ST_DIR 5
`define TCHI_ST_GO 6
`define TCHI_ST_TRK 7
`define TCHI_ST_UNABLE 8
`define TCHI_ST_WEN 9
`define TCHI_ST_TCLK 10

// Control register write bit that acts as a power clear
`define TCHI_CTRL_CLEAR 0

// Reset and preset values
`define TCHI_WORD_RST 18'h0_0000
`define TCHI_BUS_RST 32'h0000_0000
`define TCHI_WIN_PRESET 4'h0

`endif

// file: tchi_pkg.sv
// Types shared by the tape control host interface files.
// Assumes no other package.
package tchi_pkg;
	typedef logic [0:17] tchi_word_t;
	typedef logic [2:0] tchi_mode_t;
	typedef logic [0:3] tchi_unit_t;
endpackage : tchi_pkg

// file: tchi_sync.sv
// Three-stage input synchroniser, one lane per bit.
// Assumes inputs asynchronous to sys_clk; output moves once stages 2 and 3
// agree.
`timescale 1ns/1ps
module tchi_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_lane
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic q_ff;
			logic nxt_q;
			always_comb begin
				nxt_q = q_ff;
				if (s2_ff == s3_ff) begin
					nxt_q = s3_ff;
				end
			end
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					q_ff <= 1'b0;
				end else begin
					s1_ff <= d[gi];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					q_ff <= nxt_q;
				end
			end
			assign q[gi] = q_ff;
		end
	endgenerate
endmodule : tchi_sync

// file: tchi_top.sv
// Host side of a word-at-a-time tape control: pulse decode, word buffer,
// flags, status levels and an Avalon-MM register slave.
// Assumes host pulses and transport levels are asynchronous pins.
//
// Notes on behaviour
// RULE1: Flag-test pulse split by memory buffer bit 12 into error or data test.
// RULE2: Select/load pulse split by memory buffer bit 12 into select or load.
// RULE3: Data flag test skips only while the data flag is set.
// RULE4: Error flag test skips only while the error flag is set.
// RULE5: Power clear clears select, motion, mode, flags, errors, write enable.
// RULE6: Run level low stops any moving drive.
// RULE7: Data flag sets on search block number or read/write word ready.
// RULE8: Data, block and error flags drive interrupt and skip logic. Here break request uses data and block only, skip data and error only.
// RULE9: Error flag sets on end zone entry or mark-track error.
// RULE10: Error flag sets when a flag comes due before the last cleared.
// RULE11: Error flag sets on write without write switch or bad selection. Here both set it only while the go flip-flop is set.
// RULE12: Block flag sets in read/write mode when checksum word is due.
// RULE13: End status level is high while tape sits in an end zone.
// RULE14: Miss timing sets when a new flag precedes host clearing.
// RULE15: Direction status equals the reverse flip-flop.
// RULE16: Motion status equals the go flip-flop.
// RULE17: Track error status sets on timing or mark-track error.
// RULE18: Unable status high on write switch off or bad selection.
// RULE19: Eighteen output lines carry the data buffer to the host.
// RULE20: Host supplies eighteen input lines for write, select and load.
// RULE21: Track write clock enabled only while its switch is on.
// RULE22: Load takes bit 12 go, bit 13 reverse, bits 15-17 mode.
// RULE23: Host word read or write clears the data flag.
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tchi_defs.svh"
module tchi_top #(
	parameter int WIN_W = 4
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic shared_flag_test_pulse,
	input wire logic shared_select_load_pulse,
	input wire logic word_read_op,
	input wire logic word_write_op,
	input wire logic power_clear,
	input wire logic run_level,
	input wire logic memory_buffer_bit_decode,
	input wire logic [0:17] input_data_lines,
	input wire logic end_zone_in,
	input wire logic mark_track_error_in,
	input wire logic timing_error_in,
	input wire logic single_unit_ok,
	input wire logic write_switch_on,
	input wire logic block_number_done,
	input wire logic word_ready,
	input wire logic checksum_ready,
	input wire logic [0:17] tape_word,
	input wire logic track_write_clock_switch,
	input wire logic window_tick,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [0:17] output_data_lines,
	output logic skip,
	output logic data_flag,
	output logic block_flag,
	output logic error_flag,
	output logic end_status,
	output logic miss_timing,
	output logic direction_status,
	output logic motion_status,
	output logic track_error_status,
	output logic unable_status,
	output logic break_request,
	output logic [0:3] unit_select,
	output logic [2:0] mode,
	output logic write_enable,
	output logic track_write_clk_en,
	output logic [WIN_W-1:0] window_counter
);
	localparam int NPIN = 17;
	localparam int NSYNC = NPIN + 36;
	localparam logic [WIN_W-1:0] WIN_PRESET = WIN_W'(`TCHI_WIN_PRESET);
	localparam logic [WIN_W-1:0] WIN_ONE = WIN_W'(1);

	logic [NSYNC-1:0] sync_d;
	logic [NSYNC-1:0] sync_q;
	logic [NPIN-1:0] pin_q;
	logic [NPIN-1:0] prev_ff;
	logic [NPIN-1:0] rise;
	tchi_pkg::tchi_word_t host_word;
	tchi_pkg::tchi_word_t tape_q;

	assign sync_d = {input_data_lines, tape_word, window_tick,
		track_write_clock_switch, checksum_ready, word_ready,
		block_number_done, write_switch_on, single_unit_ok,
		timing_error_in, mark_track_error_in, end_zone_in,
		memory_buffer_bit_decode, run_level, power_clear, word_write_op,
		word_read_op, shared_select_load_pulse, shared_flag_test_pulse};

	tchi_sync #(
		.WIDTH(NSYNC)
	) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.d(sync_d),
		.q(sync_q)
	);

	assign pin_q = sync_q[NPIN-1:0];
	assign tape_q = sync_q[NPIN+17:NPIN];
	assign host_word = sync_q[NSYNC-1:NPIN+18];
	assign rise = pin_q & ~prev_ff;

	// Bus side state
	logic wait_ff;
	logic nxt_wait;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic soft_clear_ff;
	logic nxt_soft_clear;

	// Control side state
	tchi_pkg::tchi_word_t buf_ff;
	tchi_pkg::tchi_word_t nxt_buf;
	tchi_pkg::tchi_unit_t unit_ff;
	tchi_pkg::tchi_unit_t nxt_unit;
	tchi_pkg::tchi_mode_t mode_ff;
	tchi_pkg::tchi_mode_t nxt_mode;
	logic go_ff;
	logic nxt_go;
	logic dir_ff;
	logic nxt_dir;
	logic dflag_ff;
	logic nxt_dflag;
	logic bflag_ff;
	logic nxt_bflag;
	logic eflag_ff;
	logic nxt_eflag;
	logic miss_ff;
	logic nxt_miss;
	logic trk_err_ff;
	logic nxt_trk_err;
	logic wen_ff;
	logic nxt_wen;
	logic skip_ff;
	logic nxt_skip;
	logic end_ff;
	logic nxt_end;
	logic unable_ff;
	logic nxt_unable;
	logic brk_ff;
	logic nxt_brk;
	logic tclk_ff;
	logic nxt_tclk;
	logic [WIN_W-1:0] win_ff;
	logic [WIN_W-1:0] nxt_win;

	// Named views of the synchronised pins
	logic flag_rise;
	logic sel_rise;
	logic rd_rise;
	logic wr_rise;
	logic pclr_rise;
	logic run_lvl;
	logic bit_sel;
	logic end_lvl;
	logic end_rise;
	logic trk_rise;
	logic tim_rise;
	logic single_ok;
	logic wsw_on;
	logic blkno_rise;
	logic word_rise;
	logic cksum_rise;
	logic tsw_lvl;
	logic win_rise;

	assign flag_rise = rise[0];
	assign sel_rise = rise[1];
	assign rd_rise = rise[2];
	assign wr_rise = rise[3];
	assign pclr_rise = rise[4];
	assign run_lvl = pin_q[5];
	assign bit_sel = pin_q[6];
	assign end_lvl = pin_q[7];
	assign end_rise = rise[7];
	assign trk_rise = rise[8];
	assign tim_rise = rise[9];
	assign single_ok = pin_q[10];
	assign wsw_on = pin_q[11];
	assign blkno_rise = rise[12];
	assign word_rise = rise[13];
	assign cksum_rise = rise[14];
	assign tsw_lvl = pin_q[15];
	assign win_rise = rise[16];

	// Decoded operations
	logic ef_op;
	logic df_op;
	logic sel_op;
	logic lc_op;
	logic any_clear;
	logic search_md;
	logic rw_md;
	logic data_evt;
	logic blk_evt;
	logic unable_now;

	always_comb begin
		ef_op = flag_rise & bit_sel; // RULE1
		df_op = flag_rise & ~bit_sel; // RULE1
		sel_op = sel_rise & bit_sel; // RULE2
		lc_op = sel_rise & ~bit_sel; // RULE2
		any_clear = pclr_rise | soft_clear_ff;
		search_md = (mode_ff == `TCHI_MODE_SEARCH);
		rw_md = (mode_ff == `TCHI_MODE_READ) |
			(mode_ff == `TCHI_MODE_WRITE);
		data_evt = (search_md & blkno_rise) | (rw_md & word_rise); // RULE7
		blk_evt = rw_md & cksum_rise; // RULE12
		unable_now = ~single_ok |
			((mode_ff == `TCHI_MODE_WRITE) & ~wsw_on); // RULE11
	end

	always_comb begin
		nxt_buf = buf_ff;
		nxt_unit = unit_ff;
		nxt_mode = mode_ff;
		nxt_go = go_ff;
		nxt_dir = dir_ff;
		nxt_dflag = dflag_ff;
		nxt_bflag = bflag_ff;
		nxt_eflag = eflag_ff;
		nxt_miss = miss_ff;
		nxt_trk_err = trk_err_ff;
		nxt_wen = wen_ff;
		nxt_win = win_ff;
		nxt_skip = (df_op & dflag_ff) | (ef_op & eflag_ff); // RULE3 RULE4
		nxt_end = end_lvl; // RULE13
		nxt_unable = ~single_ok | ~wsw_on; // RULE18
		nxt_tclk = tsw_lvl; // RULE21
		if (sel_op) begin
			nxt_unit = host_word[`TCHI_UNIT_LO:`TCHI_UNIT_HI]; // RULE20
		end
		if (lc_op) begin
			nxt_go = host_word[`TCHI_GO_BIT]; // RULE22
			nxt_dir = host_word[`TCHI_DIR_BIT]; // RULE22
			nxt_mode = host_word[`TCHI_MODE_LO:`TCHI_MODE_HI]; // RULE22
			nxt_wen = (host_word[`TCHI_MODE_LO:`TCHI_MODE_HI] ==
				`TCHI_MODE_WRITE) & wsw_on;
			nxt_eflag = 1'b0;
			nxt_miss = 1'b0;
			nxt_trk_err = 1'b0;
		end
		if (!run_lvl) begin
			nxt_go = 1'b0; // RULE6
		end
		// Host service acknowledges the word, flags then may set again
		if (rd_rise | wr_rise) begin
			nxt_dflag = 1'b0; // RULE23
			nxt_bflag = 1'b0;
		end
		if (wr_rise) begin
			nxt_buf = host_word; // RULE20
		end else if (data_evt & (mode_ff != `TCHI_MODE_WRITE)) begin
			nxt_buf = tape_q;
		end
		if (data_evt) begin
			nxt_dflag = 1'b1; // RULE7
		end
		if (blk_evt) begin
			nxt_bflag = 1'b1; // RULE12
		end
		if ((data_evt | blk_evt) & (dflag_ff | bflag_ff)) begin
			nxt_miss = 1'b1; // RULE14
			nxt_eflag = 1'b1; // RULE10
		end
		if (end_rise | trk_rise) begin
			nxt_eflag = 1'b1; // RULE9
		end
		if (trk_rise | tim_rise) begin
			nxt_trk_err = 1'b1; // RULE17
		end
		if (unable_now & go_ff) begin
			nxt_eflag = 1'b1; // RULE11
		end
		if (win_rise) begin
			nxt_win = win_ff + WIN_ONE;
		end
		if (any_clear) begin
			nxt_unit = '0; // RULE5
			nxt_go = 1'b0; // RULE5
			nxt_dir = 1'b0;
			nxt_mode = `TCHI_MODE_MOVE; // RULE5
			nxt_dflag = 1'b0; // RULE5
			nxt_bflag = 1'b0; // RULE5
			nxt_eflag = 1'b0; // RULE5
			nxt_miss = 1'b0; // RULE5
			nxt_trk_err = 1'b0; // RULE5
			nxt_wen = 1'b0; // RULE5
			nxt_win = WIN_PRESET; // RULE5
		end
		nxt_brk = nxt_dflag | nxt_bflag; // RULE8
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prev_ff <= '0;
			buf_ff <= `TCHI_WORD_RST;
			unit_ff <= '0;
			mode_ff <= `TCHI_MODE_MOVE;
			go_ff <= 1'b0;
			dir_ff <= 1'b0;
			dflag_ff <= 1'b0;
			bflag_ff <= 1'b0;
			eflag_ff <= 1'b0;
			miss_ff <= 1'b0;
			trk_err_ff <= 1'b0;
			wen_ff <= 1'b0;
			skip_ff <= 1'b0;
			end_ff <= 1'b0;
			unable_ff <= 1'b0;
			brk_ff <= 1'b0;
			tclk_ff <= 1'b0;
			win_ff <= WIN_PRESET;
		end else begin
			prev_ff <= pin_q;
			buf_ff <= nxt_buf;
			unit_ff <= nxt_unit;
			mode_ff <= nxt_mode;
			go_ff <= nxt_go;
			dir_ff <= nxt_dir;
			dflag_ff <= nxt_dflag;
			bflag_ff <= nxt_bflag;
			eflag_ff <= nxt_eflag;
			miss_ff <= nxt_miss;
			trk_err_ff <= nxt_trk_err;
			wen_ff <= nxt_wen;
			skip_ff <= nxt_skip;
			end_ff <= nxt_end;
			unable_ff <= nxt_unable;
			brk_ff <= nxt_brk;
			tclk_ff <= nxt_tclk;
			win_ff <= nxt_win;
		end
	end

	// Avalon slave: one wait cycle, answer on the second cycle
	logic [31:0] status_word;
	logic [31:0] ctrl_word;

	always_comb begin
		status_word = `TCHI_BUS_RST;
		status_word[`TCHI_ST_DATA] = dflag_ff;
		status_word[`TCHI_ST_BLOCK] = bflag_ff;
		status_word[`TCHI_ST_ERROR] = eflag_ff;
		status_word[`TCHI_ST_END] = end_ff;
		status_word[`TCHI_ST_MISS] = miss_ff;
		status_word[`TCHI_ST_DIR] = dir_ff;
		status_word[`TCHI_ST_GO] = go_ff;
		status_word[`TCHI_ST_TRK] = trk_err_ff;
		status_word[`TCHI_ST_UNABLE] = unable_ff;
		status_word[`TCHI_ST_WEN] = wen_ff;
		status_word[`TCHI_ST_TCLK] = tclk_ff;
		ctrl_word = {21'h00_0000, unit_ff, mode_ff, dir_ff, go_ff, 2'h0};
	end

	always_comb begin
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		nxt_soft_clear = 1'b0;
		if (wait_ff & (avs_read | avs_write)) begin
			nxt_wait = 1'b0;
			nxt_rdata = `TCHI_BUS_RST;
			if (avs_read) begin
				case (avs_address)
					`TCHI_OFS_STATUS: begin
						nxt_rdata = status_word;
					end
					`TCHI_OFS_DATA: begin
						nxt_rdata = {14'h0000, buf_ff};
					end
					`TCHI_OFS_CTRL: begin
						nxt_rdata = ctrl_word;
					end
					default: begin
						nxt_rdata = `TCHI_BUS_RST;
					end
				endcase
			end
		end
		if (!wait_ff & avs_write & (avs_address == `TCHI_OFS_CTRL)) begin
			nxt_soft_clear = avs_writedata[`TCHI_CTRL_CLEAR]; // RULE5
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wait_ff <= 1'b1;
			rdata_ff <= `TCHI_BUS_RST;
			soft_clear_ff <= 1'b0;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			soft_clear_ff <= nxt_soft_clear;
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign output_data_lines = buf_ff; // RULE19
	assign skip = skip_ff;
	assign data_flag = dflag_ff; // RULE8
	assign block_flag = bflag_ff; // RULE8
	assign error_flag = eflag_ff; // RULE8
	assign end_status = end_ff;
	assign miss_timing = miss_ff;
	assign direction_status = dir_ff; // RULE15
	assign motion_status = go_ff; // RULE16
	assign track_error_status = trk_err_ff; // RULE17
	assign unable_status = unable_ff;
	assign break_request = brk_ff;
	assign unit_select = unit_ff;
	assign mode = mode_ff;
	assign write_enable = wen_ff;
	assign track_write_clk_en = tclk_ff;
	assign window_counter = win_ff;
endmodule : tchi_top

// file: tchi_props.sv
// Port-level checks on the tape control host interface.
// Assumes pins settle through the synchroniser within eight clocks.
`timescale 1ns/1ps
module tchi_props (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic run_level,
	input wire logic end_zone_in,
	input wire logic single_unit_ok,
	input wire logic write_switch_on,
	input wire logic track_write_clock_switch,
	input wire logic avs_waitrequest,
	input wire logic skip,
	input wire logic data_flag,
	input wire logic block_flag,
	input wire logic error_flag,
	input wire logic end_status,
	input wire logic miss_timing,
	input wire logic motion_status,
	input wire logic unable_status,
	input wire logic break_request,
	input wire logic track_write_clk_en
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	property p_skip;
		skip |-> $past(data_flag || error_flag);
	endproperty
	a_skip: assert property (p_skip)
		else $error("skip without a set flag");
	property p_brk;
		break_request == (data_flag || block_flag);
	endproperty
	a_brk: assert property (p_brk)
		else $error("break request does not follow flags");
	property p_run;
		!run_level [*8] |-> !motion_status;
	endproperty
	a_run: assert property (p_run)
		else $error("motion while run is low");
	property p_tclk;
		$stable(track_write_clock_switch) [*8]
			|-> track_write_clk_en == track_write_clock_switch;
	endproperty
	a_tclk: assert property (p_tclk)
		else $error("track clock enable differs from switch");
	property p_end;
		$stable(end_zone_in) [*8] |-> end_status == end_zone_in;
	endproperty
	a_end: assert property (p_end)
		else $error("end status differs from end zone");
	property p_err_end;
		$rose(end_status) |-> ##[0:1] error_flag;
	endproperty
	a_err_end: assert property (p_err_end)
		else $error("end zone did not raise error");
	property p_unable;
		$stable({write_switch_on, single_unit_ok}) [*8]
			|-> unable_status == !(write_switch_on && single_unit_ok);
	endproperty
	a_unable: assert property (p_unable)
		else $error("unable status wrong");
	property p_miss;
		$rose(miss_timing) |-> $past(data_flag || block_flag);
	endproperty
	a_miss: assert property (p_miss)
		else $error("miss timing without pending flag");
	c_skip: cover property (skip);
	c_miss: cover property ($rose(miss_timing));
	c_bus: cover property (!avs_waitrequest);
endmodule : tchi_props

bind tchi_top tchi_props tchi_props_inst (.*);

// file: tchi_host.sv
// Host I/O bus model: pulsed instructions with held data lines.
// Assumes a synchronising device; pulses last five clocks.
`timescale 1ns/1ps
module tchi_host (
	input wire logic sys_clk,
	output logic [4:0] pls,
	output logic memory_buffer_bit_decode,
	output logic [0:17] input_data_lines
);
	initial begin
		pls = 5'h0;
		memory_buffer_bit_decode = 1'b0;
		input_data_lines = 18'h0_0000;
	end
	// Kinds: 0 flag test, 1 select/load, 2 read, 3 write, 4 clear
	task automatic op(input int k, input logic b, input logic [0:17] w);
		@(posedge sys_clk);
		memory_buffer_bit_decode <= b;
		input_data_lines <= w;
		repeat (5) @(posedge sys_clk);
		pls[k] <= 1'b1;
		repeat (5) @(posedge sys_clk);
		pls[k] <= 1'b0;
		input_data_lines <= ~w;
		memory_buffer_bit_decode <= ~b;
		repeat (8) @(posedge sys_clk);
	endtask : op
endmodule : tchi_host

// file: tb_top.sv
// Self-checking bench for the tape control host interface.
// Assumes tchi_host drives host pins and tchi_props is bound.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic [0:17] w;
		logic [2:0] m;
		logic r;
		logic g;
	} tchi_row_t;
	logic sys_clk, rstn, run_level, end_zone_in, single_unit_ok;
	logic write_switch_on, track_write_clock_switch, avs_read, avs_write;
	logic memory_buffer_bit_decode, avs_waitrequest, skip, data_flag;
	logic block_flag, error_flag, end_status, miss_timing, direction_status;
	logic motion_status, track_error_status, unable_status, break_request;
	logic write_enable, track_write_clk_en, sk_seen;
	logic [0:17] input_data_lines, output_data_lines, tape_word;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_address, window_counter;
	logic [0:3] unit_select;
	logic [2:0] mode;
	logic [5:0] ev;
	logic [4:0] pls;
	int miscompares, check_count, cyc;
	tchi_row_t rows [4] = '{'{18'h0_0020, 3'h0, 1'b0, 1'b1},
		'{18'h0_0011, 3'h1, 1'b1, 1'b0}, '{18'h0_0032, 3'h2, 1'b1, 1'b1},
		'{18'h0_0023, 3'h3, 1'b0, 1'b1}};
	tchi_host tchi_host_inst (.*);
	tchi_top #(.WIN_W(4)) tchi_top_inst (.*,
		.shared_flag_test_pulse(pls[0]), .shared_select_load_pulse(pls[1]),
		.word_read_op(pls[2]), .word_write_op(pls[3]), .power_clear(pls[4]),
		.word_ready(ev[0]), .checksum_ready(ev[1]), .block_number_done(ev[2]),
		.mark_track_error_in(ev[3]), .timing_error_in(ev[4]),
		.window_tick(ev[5]));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report;
		end
	end
	always @(posedge sys_clk) if (skip === 1'b1) sk_seen <= 1'b1;
	task automatic final_report;
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a);
		int n;
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= 32'h0000_0001;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) begin
			miscompares++;
			$display("[ERR] %0t bus wait timeout", $time);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic pin(input int i);
		@(posedge sys_clk);
		ev[i] <= 1'b1;
		repeat (5) @(posedge sys_clk);
		ev[i] <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask : pin
	task automatic hop(input int k, input logic b, input logic [0:17] w);
		sk_seen <= 1'b0;
		tchi_host_inst.op(k, b, w);
	endtask : hop
	initial begin
		{rstn, end_zone_in, track_write_clock_switch, avs_read} = 4'h0;
		{avs_write, sk_seen, ev, avs_address} = 12'h000;
		{run_level, single_unit_ok, write_switch_on} = 3'h7;
		avs_writedata = 32'h0000_0000;
		tape_word = 18'h1_2345;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk({avs_waitrequest, data_flag, error_flag, motion_status}, 8);
		repeat (6) @(posedge sys_clk);
		foreach (rows[i]) begin
			hop(1, 1'b0, rows[i].w);
			chk({mode, direction_status, motion_status}, rows[i][4:0]);
			bus(1'b0, 4'h8);
			chk(q[6:2], rows[i][4:0]);
		end
		chk(write_enable, 1);
		pin(0);
		chk(data_flag, 1);
		hop(0, 1'b0, 18'h0_0000);
		chk(sk_seen, 1);
		hop(0, 1'b1, 18'h0_0000);
		chk(sk_seen, 0);
		hop(3, 1'b0, 18'h2_5A5A);
		chk({data_flag, output_data_lines}, 19'h2_5A5A);
		bus(1'b0, 4'h4);
		chk(q, 32'h0002_5A5A);
		pin(0);
		pin(0);
		chk({miss_timing, error_flag}, 2'b11);
		hop(0, 1'b1, 18'h0_0000);
		chk(sk_seen, 1);
		pin(1);
		chk({block_flag, break_request}, 2'b11);
		hop(2, 1'b0, 18'h0_0000);
		chk(data_flag, 0);
		hop(4, 1'b0, 18'h0_0000);
		chk({error_flag, block_flag, motion_status, mode, write_enable}, 0);
		hop(1, 1'b0, 18'h0_0001);
		pin(2);
		chk({data_flag, output_data_lines}, 19'h5_2345);
		hop(1, 1'b1, 18'h0_A000);
		chk(unit_select, 4'hA);
		end_zone_in <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk({end_status, error_flag}, 2'b11);
		end_zone_in <= 1'b0;
		hop(1, 1'b0, 18'h0_0000);
		pin(4);
		chk({track_error_status, error_flag}, 2'b10);
		pin(3);
		chk({track_error_status, error_flag}, 2'b11);
		single_unit_ok <= 1'b0;
		hop(1, 1'b0, 18'h0_0020);
		chk({unable_status, error_flag}, 2'b11);
		single_unit_ok <= 1'b1;
		write_switch_on <= 1'b0;
		run_level <= 1'b0;
		track_write_clock_switch <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk({motion_status, track_write_clk_en}, 2'b01);
		chk(unable_status, 1);
		write_switch_on <= 1'b1;
		run_level <= 1'b1;
		track_write_clock_switch <= 1'b0;
		repeat (3) pin(5);
		chk({window_counter, track_write_clk_en}, 5'h06);
		chk(unable_status, 0);
		bus(1'b1, 4'h8);
		repeat (2) @(posedge sys_clk);
		chk({window_counter, data_flag, unit_select}, 0);
		bus(1'b0, 4'hC);
		chk(q, 0);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({avs_waitrequest, unable_status, motion_status, window_counter},
			7'h40);
		rstn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk({unable_status, error_flag}, 0);
		final_report;
	end
endmodule : tb_top
